// ===== hdl/bka_pkg.sv
package bka_pkg;

    // breakpoint count and the first opcode served by pair zero
    localparam int          NUM_PAIRS      = 8;
    localparam logic [15:0] BKPT_OPCODE_0  = 16'h4848;
    localparam logic [15:0] BKPT_OPCODE_7  = 16'h484F;

    // control word layout
    localparam int          CTRL_ENABLE_BIT = 15;
    localparam int          CTRL_COUNT_LSB  = 0;
    localparam int          CTRL_COUNT_W    = 8;

    // cpu space decode for the acknowledge cycle
    localparam logic [2:0]  FC_CPU_SPACE    = 3'h7;
    localparam logic [3:0]  CPU_TYPE_BKPT   = 4'h0;
    localparam int          BKPT_NUM_LSB    = 2;

    // register select codes on the register move port
    localparam logic [3:0]  SEL_OPCODE_0    = 4'h0;
    localparam logic [3:0]  SEL_CONTROL_0   = 4'h8;

    // reset value of the enable bit
    localparam logic        ENABLE_RESET    = 1'b0;

    typedef enum {
        BKA_IDLE,
        BKA_ANSWER,
        BKA_WAIT_END
    } bka_state_type;

endpackage : bka_pkg

// ===== hdl/bka_pin_sync.sv
`timescale 1ns/1ps

// four flops per bit, three stages and an output; a change counts when stages two and three agree
module bka_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } bka_sync_type;

    bka_sync_type sync_reg;
    bka_sync_type sync_next;

    always_comb begin
        sync_next    = sync_reg;
        sync_next.s1 = pin_in;
        sync_next.s2 = sync_reg.s1;
        sync_next.s3 = sync_reg.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (sync_reg.s2[i] == sync_reg.s3[i]) begin
                sync_next.q[i] = sync_reg.s3[i];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign pin_out = sync_reg.q;

endmodule : bka_pin_sync

// ===== hdl/bka_unit.sv
`timescale 1ns/1ps

// Functional notes
// - eight register pairs serve opcodes 4848 to 484F in order, pair n for n.
// - each replacement opcode register holds any 16-bit value and drives it.
// - replacement opcode registers are readable and writable by register move.
// - with the control enable bit clear the acknowledge ends in bus error.
// - reset clears every enable bit and leaves the skip counts alone.
// - the low eight control bits hold the skip count.
// - enabled with nonzero count, the opcode is driven with a size acknowledge.
// - each cycle that returns the opcode decrements its count by one.
// - with a zero count the cycle ends in bus error and no opcode.
// - control bits 8 to 14 read as zero and are stored as nothing.
// - control registers are readable and writable by register move.
module bka_unit #(
    parameter int NPAIR = bka_pkg::NUM_PAIRS
) (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        as_n,
    input  wire logic        rw,
    input  wire logic [2:0]  fc,
    input  wire logic [19:0] addr,
    output logic      [15:0] data_out,
    output logic             data_oe,
    output logic             dsack_n,
    output logic             berr_n,
    input  wire logic        move_wr,
    input  wire logic        move_rd,
    input  wire logic [3:0]  move_sel,
    input  wire logic [15:0] move_wdata,
    output logic      [15:0] move_rdata,
    output logic             move_rvalid
);

    localparam int CW = bka_pkg::CTRL_COUNT_W;

    // =====================================================
    // pin synchronisers
    // =====================================================
    // strobe enters inverted: cleared flops mean an idle bus, so no
    // phantom strobe is seen in the cycles after a reset
    logic [25:0] pins_s;

    bka_pin_sync #(
        .WIDTH (26)
    ) u_sync (
        .mclk    (mclk),
        .nrst    (nrst),
        .pin_in  ({~as_n, rw, fc, addr, 1'b0}),
        .pin_out (pins_s)
    );

    logic        as_s;
    logic        rw_s;
    logic [2:0]  fc_s;
    logic [19:0] addr_s;

    assign as_s   = pins_s[25];
    assign rw_s   = pins_s[24];
    assign fc_s   = pins_s[23:21];
    assign addr_s = pins_s[20:1];

    // =====================================================
    // state
    // =====================================================
    typedef struct packed {
        bka_pkg::bka_state_type st;
        logic [NPAIR-1:0][15:0]   opcode;
        logic [NPAIR-1:0]         enable;
        logic [NPAIR-1:0][CW-1:0] count;
        logic [2:0]  sel;
        logic        give;
        logic [15:0] data;
        logic        oe;
        logic        dsack;
        logic        berr;
        logic [15:0] rdata;
        logic        rvalid;
    } bka_core_type;

    bka_core_type core_reg;
    bka_core_type core_next;

    logic       ack_cycle;
    logic [2:0] bk_num;

    // only the breakpoint number and cpu type fields matter; other zero-filled bits ignored
    assign bk_num    = addr_s[bka_pkg::BKPT_NUM_LSB +: 3];
    assign ack_cycle = as_s && rw_s && fc_s == bka_pkg::FC_CPU_SPACE
                       && addr_s[19:16] == bka_pkg::CPU_TYPE_BKPT;

    always_comb begin
        core_next        = core_reg;
        core_next.rvalid = 1'b0;
        // register move port
        if (move_wr) begin
            if (move_sel[3] == 1'b0) begin
                core_next.opcode[move_sel[2:0]] = move_wdata;
            end else begin
                core_next.enable[move_sel[2:0]] =
                    move_wdata[bka_pkg::CTRL_ENABLE_BIT];
                core_next.count[move_sel[2:0]] =
                    move_wdata[bka_pkg::CTRL_COUNT_LSB +: CW];
            end
        end
        if (move_rd) begin
            core_next.rvalid = 1'b1;
            if (move_sel[3] == 1'b0) begin
                core_next.rdata = core_reg.opcode[move_sel[2:0]];
            end else begin
                core_next.rdata = {core_reg.enable[move_sel[2:0]],
                                   7'h00,
                                   core_reg.count[move_sel[2:0]]};
            end
        end
        case (core_reg.st)
            bka_pkg::BKA_IDLE: begin
                if (ack_cycle) begin
                    // outcome fixed from the values seen here
                    core_next.sel  = bk_num;
                    core_next.give = core_reg.enable[bk_num]
                                     && core_reg.count[bk_num] != '0;
                    core_next.st   = bka_pkg::BKA_ANSWER;
                end
            end
            bka_pkg::BKA_ANSWER: begin
                if (core_reg.give) begin
                    core_next.data  = core_reg.opcode[core_reg.sel];
                    core_next.oe    = 1'b1;
                    core_next.dsack = 1'b1;
                    // decrement wins over a same-cycle register move
                    core_next.count[core_reg.sel] =
                        core_reg.count[core_reg.sel] - 8'h01;
                end else begin
                    core_next.berr = 1'b1;
                end
                core_next.st = bka_pkg::BKA_WAIT_END;
            end
            bka_pkg::BKA_WAIT_END: begin
                if (!as_s) begin
                    core_next.oe    = 1'b0;
                    core_next.dsack = 1'b0;
                    core_next.berr  = 1'b0;
                    core_next.st    = bka_pkg::BKA_IDLE;
                end
            end
            default: begin
                core_next.st = bka_pkg::BKA_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            // counts and opcodes keep their value across reset
            core_reg.st     <= bka_pkg::BKA_IDLE;
            core_reg.enable <= {NPAIR{bka_pkg::ENABLE_RESET}};
            core_reg.sel    <= 3'h0;
            core_reg.give   <= 1'b0;
            core_reg.data   <= 16'h0000;
            core_reg.oe     <= 1'b0;
            core_reg.dsack  <= 1'b0;
            core_reg.berr   <= 1'b0;
            core_reg.rdata  <= 16'h0000;
            core_reg.rvalid <= 1'b0;
            core_reg.opcode <= core_reg.opcode;
            core_reg.count  <= core_reg.count;
        end else begin
            core_reg <= core_next;
        end
    end

    assign data_out    = core_reg.data;
    assign data_oe     = core_reg.oe;
    assign dsack_n     = ~core_reg.dsack;
    assign berr_n      = ~core_reg.berr;
    assign move_rdata  = core_reg.rdata;
    assign move_rvalid = core_reg.rvalid;

    // =====================================================
    // checks
    // =====================================================
    a_never_both: assert property (@(posedge mclk) disable iff (!nrst)
        !(core_reg.dsack && core_reg.berr))
        else $error("size acknowledge and bus error together");

    a_disabled_errs: assert property (@(posedge mclk) disable iff (!nrst)
        (core_reg.st == bka_pkg::BKA_IDLE && ack_cycle
         && !core_reg.enable[bk_num])
        |=> ##1 core_reg.berr)
        else $error("disabled breakpoint not ended by bus error");

    a_zero_errs: assert property (@(posedge mclk) disable iff (!nrst)
        (core_reg.st == bka_pkg::BKA_IDLE && ack_cycle
         && core_reg.count[bk_num] == '0)
        |=> ##1 (core_reg.berr && !core_reg.oe))
        else $error("zero count not ended by bus error");

    a_give_opcode: assert property (@(posedge mclk) disable iff (!nrst)
        (core_reg.st == bka_pkg::BKA_ANSWER && core_reg.give)
        |=> (core_reg.dsack
             && core_reg.data == $past(core_reg.opcode[core_reg.sel])))
        else $error("replacement opcode not driven");

    a_count_dec: assert property (@(posedge mclk) disable iff (!nrst)
        (core_reg.st == bka_pkg::BKA_ANSWER && core_reg.give)
        |=> core_reg.count[$past(core_reg.sel)]
            == $past(core_reg.count[core_reg.sel]) - 8'h01)
        else $error("skip count not decremented by one");

    a_ctrl_zeros: assert property (@(posedge mclk) disable iff (!nrst)
        core_reg.rvalid && $past(move_sel[3]) |-> core_reg.rdata[14:8] == 7'h00)
        else $error("control reserved bits not zero");

    a_reset_enable: assert property (@(posedge mclk)
        !nrst |=> core_reg.enable == '0)
        else $error("enable not cleared by reset");

    a_ack_closes: assert property (@(posedge mclk) disable iff (!nrst)
        (core_reg.dsack || core_reg.berr) && !as_s
        |=> !(core_reg.dsack || core_reg.berr))
        else $error("termination held after strobe released");

    // =====================================================
    // checks: reset and termination shape
    // =====================================================
    a_reset_outputs: assert property (@(posedge mclk)
        !nrst |=> (!core_reg.dsack && !core_reg.berr && !core_reg.oe))
        else $error("bus outputs not released by reset");

    a_berr_no_oe: assert property (@(posedge mclk) disable iff (!nrst)
        core_reg.berr |-> !core_reg.oe)
        else $error("data driven during bus error");

    a_oe_with_dsack: assert property (@(posedge mclk) disable iff (!nrst)
        core_reg.oe == core_reg.dsack)
        else $error("data enable apart from size acknowledge");

    // =====================================================
    // checks: sampling at the take edge
    // =====================================================
    // outcome must follow the values seen when the cycle was taken,
    // not whatever a later register move leaves behind
    a_take_answer: assert property (@(posedge mclk) disable iff (!nrst)
        (core_reg.st == bka_pkg::BKA_IDLE && ack_cycle)
        |=> core_reg.st == bka_pkg::BKA_ANSWER)
        else $error("acknowledge cycle not taken");

    a_give_sampled: assert property (@(posedge mclk) disable iff (!nrst)
        (core_reg.st == bka_pkg::BKA_IDLE && ack_cycle)
        |=> core_reg.give == $past(core_reg.enable[bk_num]
                                   && core_reg.count[bk_num] != '0))
        else $error("outcome not fixed at cycle start");

    a_sel_number: assert property (@(posedge mclk) disable iff (!nrst)
        (core_reg.st == bka_pkg::BKA_IDLE && ack_cycle)
        |=> core_reg.sel == $past(bk_num))
        else $error("pair not picked from address number");

    // =====================================================
    // checks: register move port
    // =====================================================
    a_opcode_write: assert property (@(posedge mclk) disable iff (!nrst)
        (move_wr && !move_sel[3])
        |=> core_reg.opcode[$past(move_sel[2:0])] == $past(move_wdata))
        else $error("opcode register write lost");

    a_ctrl_write: assert property (@(posedge mclk) disable iff (!nrst)
        (move_wr && move_sel[3])
        |=> core_reg.enable[$past(move_sel[2:0])]
            == $past(move_wdata[bka_pkg::CTRL_ENABLE_BIT]))
        else $error("enable bit write lost");

    a_opcode_read: assert property (@(posedge mclk) disable iff (!nrst)
        (move_rd && !move_sel[3])
        |=> core_reg.rdata == $past(core_reg.opcode[move_sel[2:0]]))
        else $error("opcode register read wrong");

    a_rvalid_pulse: assert property (@(posedge mclk) disable iff (!nrst)
        move_rd |=> core_reg.rvalid)
        else $error("read not answered next cycle");

    a_rvalid_idle: assert property (@(posedge mclk) disable iff (!nrst)
        !move_rd |=> !core_reg.rvalid)
        else $error("read valid without a read");

endmodule : bka_unit

// ===== sim/bka_host.sv
`timescale 1ns/1ps

// =========================================
// processor side of the acknowledge cycle
module bka_host (
    input  wire logic        mclk,
    input  wire logic [15:0] data_out,
    input  wire logic        data_oe,
    input  wire logic        dsack_n,
    input  wire logic        berr_n,
    output logic             as_n,
    output logic             rw,
    output logic      [2:0]  fc,
    output logic      [19:0] addr
);
    initial begin
        as_n = 1'b1;
        rw   = 1'b0;
        fc   = 3'h0;
        addr = 20'hFFFFF;
    end

    // strobe held until a termination is sampled, then let go
    task automatic ack_cycle(input logic [2:0] num, output logic [15:0] d,
                             output logic berr, oe, ok);
        int i;
        ok = 1'b0;
        @(posedge mclk);
        #2;
        rw   = 1'b1;
        fc   = bka_pkg::FC_CPU_SPACE;
        addr = {bka_pkg::CPU_TYPE_BKPT, 11'h000, num, 2'h0};
        as_n = 1'b0;
        for (i = 0; i < 40 && !ok; i++) begin
            @(posedge mclk);
            if (dsack_n === 1'b0 || berr_n === 1'b0) begin
                ok   = 1'b1;
                d    = data_out;
                berr = (berr_n === 1'b0);
                oe   = data_oe;
            end
        end
        #2;
        as_n = 1'b1;
        rw   = 1'b0;
        fc   = 3'h0;
        // released lines do not keep the last value
        addr = ~addr;
        for (i = 0; i < 40 && !(dsack_n === 1'b1 && berr_n === 1'b1); i++)
            @(posedge mclk);
    endtask : ack_cycle
endmodule : bka_host

// ===== sim/testbench.sv
`timescale 1ns/1ps

// =========================================
// bench top
module testbench;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic        move_wr = 1'b0;
    logic        move_rd = 1'b0;
    logic [3:0]  move_sel = 4'h0;
    logic [15:0] move_wdata = 16'h0000;
    logic        as_n, rw, data_oe, dsack_n, berr_n, move_rvalid;
    logic [2:0]  fc;
    logic [19:0] addr;
    logic [15:0] data_out, move_rdata;
    int          n_fail = 0;
    int          checked = 0;

    always #12.5 mclk = ~mclk;

    bka_unit dut (.mclk(mclk), .nrst(nrst), .as_n(as_n), .rw(rw), .fc(fc),
        .addr(addr), .data_out(data_out), .data_oe(data_oe),
        .dsack_n(dsack_n), .berr_n(berr_n), .move_wr(move_wr),
        .move_rd(move_rd), .move_sel(move_sel), .move_wdata(move_wdata),
        .move_rdata(move_rdata), .move_rvalid(move_rvalid));
    bka_host host (.mclk(mclk), .data_out(data_out), .data_oe(data_oe),
        .dsack_n(dsack_n), .berr_n(berr_n), .as_n(as_n), .rw(rw), .fc(fc),
        .addr(addr));

    task automatic check(input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test;
        if (n_fail == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    task automatic mv_wr(input logic [3:0] sel, input logic [15:0] d);
        @(posedge mclk);
        #2;
        move_wr = 1'b1;
        move_sel = sel;
        move_wdata = d;
        @(posedge mclk);
        #2;
        move_wr = 1'b0;
    endtask : mv_wr

    // read data looked at in the one cycle that rvalid stands
    task automatic mv_rd(input logic [3:0] sel, input logic [15:0] exp);
        @(posedge mclk);
        #2;
        move_rd = 1'b1;
        move_sel = sel;
        @(posedge mclk);
        #2;
        move_rd = 1'b0;
        check({15'h0, move_rvalid}, 16'h0001);
        check(move_rdata, exp);
    endtask : mv_rd

    task automatic ack(input logic [2:0] n, input logic [15:0] exp,
                       input logic exp_berr);
        logic [15:0] d;
        logic b, oe, ok;
        host.ack_cycle(n, d, b, oe, ok);
        check({15'h0, ok}, 16'h0001);
        check({15'h0, b}, {15'h0, exp_berr});
        check({15'h0, oe}, {15'h0, !exp_berr});
        if (!exp_berr)
            check(d, exp);
    endtask : ack

    task automatic t_reset;
        mv_wr(4'hB, 16'h8005);
        @(posedge mclk);
        #2;
        nrst = 1'b0;
        repeat (2) @(posedge mclk);
        #2;
        nrst = 1'b1;
        repeat (4) @(posedge mclk);
        mv_rd(4'hB, 16'h0005);
        ack(3'h3, 16'h0000, 1'b1);
    endtask : t_reset

    task automatic t_pairs;
        for (int n = 0; n < 8; n++) begin
            mv_wr(n[3:0], {8'hC3, 5'h00, n[2:0]});
            mv_wr(4'h8 | n[3:0], 16'h8002);
        end
        for (int n = 0; n < 8; n++) begin
            ack(n[2:0], {8'hC3, 5'h00, n[2:0]}, 1'b0);
            mv_rd(4'h8 | n[3:0], 16'h8001);
            mv_rd(n[3:0], {8'hC3, 5'h00, n[2:0]});
        end
        for (int n = 0; n < 8; n++) begin
            ack(n[2:0], {8'hC3, 5'h00, n[2:0]}, 1'b0);
            ack(n[2:0], 16'h0000, 1'b1);
            mv_rd(4'h8 | n[3:0], 16'h8000);
        end
    endtask : t_pairs

    task automatic t_disabled;
        mv_wr(4'hD, 16'h0007);
        ack(3'h5, 16'h0000, 1'b1);
        mv_rd(4'hD, 16'h0007);
        // resume with the breakpoint left in place: count of one
        mv_wr(4'hD, 16'h8001);
        ack(3'h5, {8'hC3, 5'h00, 3'h5}, 1'b0);
        ack(3'h5, 16'h0000, 1'b1);
    endtask : t_disabled

    initial begin
        repeat (8) @(posedge mclk);
        #2;
        nrst = 1'b1;
        repeat (4) @(posedge mclk);
        t_reset;
        t_pairs;
        t_disabled;
        stop_test;
    end

    initial begin
        #400000;
        n_fail++;
        stop_test;
    end
endmodule : testbench
